// ==== design/dcsi_filter.sv ====
// noise filter for one synchronised safety input channel
// assumes raw_in is already on sys_clk, filter time given in clock cycles
module dcsi_filter (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // input and setting
    input  wire logic                       raw_in,
    input  wire logic [dcsi_pkg::FILT_W-1:0] filt_cycles,
    // filtered level
    output logic                            level_q
);

    // ==========================================
    // stability counter
    logic [dcsi_pkg::FILT_W-1:0] cnt_q;
    logic [dcsi_pkg::FILT_W-1:0] cnt_d;
    logic [dcsi_pkg::FILT_W:0]   cnt_inc;
    wire                         differs = raw_in != level_q;
    wire                         expired;

    assign cnt_inc = {1'b0, cnt_q} + {{dcsi_pkg::FILT_W{1'b0}}, 1'b1};
    assign expired = cnt_inc >= {1'b0, filt_cycles};                    // RULE21
    assign cnt_d   = (differs && !expired) ? cnt_inc[dcsi_pkg::FILT_W-1:0]
                                           : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (differs && expired) begin
                level_q <= raw_in;                                      // RULE20
            end
        end
    end

endmodule

// ==== design/dcsi_pkg.sv ====
// constants, register map and command codes for the dual channel safety input block
// assumes one 50 mhz clock and an axi4-lite register bus with 32-bit data
// How it works
// RULE1 - pair channels disagree: command inactive
// RULE2 - command active only with both channels on
// RULE3 - disagreement past limit raises mismatch alarm and stop one; code raises them only while network control is off
// RULE4 - mismatch limit zero disables the alarm for that pair
// RULE5 - each pair has its own mismatch limit
// RULE6 - source drives each selected pair on, off, on, one at a time
// RULE7 - all selected pairs done: warning clears, torque off releases
// RULE8 - source holds pairs not under diagnosis on
// RULE9 - pair diagnosed only when mapped and enabled
// RULE10 - unmapped pair toggling leaves diagnosis unaffected
// RULE11 - none selected: release after internal diagnosis and all inputs on
// RULE12 - auto activated command is active whatever its inputs
// RULE13 - command routed to first axis or all three
// RULE14 - each pair maps to one of twelve commands
// RULE15 - each pair has its own filter time
// RULE16 - switch or pulse-free source: filter at least 1.00 ms
// RULE17 - with test pulses: filter exceeds pulse off time by 1.00 ms
// RULE18 - external controller pulses channels a and b at different times
// RULE19 - under network control pins steer no command
// RULE20 - input change reaches command after the pair's filter time
// RULE21 - filtered level follows raw only after a full filter time
package dcsi_pkg;

    // ==========================================
    // sizes
    localparam int NUM_PAIRS = 3;
    localparam int NUM_CMDS  = 12;
    localparam int FILT_W    = 20;
    localparam int MISM_W    = 16;
    localparam int MAP_W     = 4;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // ==========================================
    // register offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_AUTO   = 8'h04;
    localparam logic [7:0] OFF_MAP    = 8'h08;
    localparam logic [7:0] OFF_FILT1  = 8'h0c;
    localparam logic [7:0] OFF_FILT2  = 8'h10;
    localparam logic [7:0] OFF_FILT3  = 8'h14;
    localparam logic [7:0] OFF_MISM1  = 8'h18;
    localparam logic [7:0] OFF_MISM2  = 8'h1c;
    localparam logic [7:0] OFF_MISM3  = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_CMDS   = 8'h28;

    // ==========================================
    // field positions
    localparam int CTRL_ROUTE_LSB = 0;
    localparam int CTRL_NET_BIT   = 3;
    localparam int CTRL_DIAG_LSB  = 4;
    localparam int CTRL_CLR_BIT   = 8;
    localparam int ST_FA_LSB      = 0;
    localparam int ST_FB_LSB      = 3;
    localparam int ST_MISM_LSB    = 6;
    localparam int ST_ALARM_BIT   = 9;
    localparam int ST_WARN_BIT    = 10;
    localparam int ST_REL_BIT     = 11;

    // ==========================================
    // reset values
    localparam logic [31:0]       CTRL_RST = 32'h0000_0000;
    localparam logic [11:0]       AUTO_RST = 12'h000;
    localparam logic [11:0]       MAP_RST  = 12'h000;
    localparam logic [FILT_W-1:0] FILT_RST = 20'h0c350;
    localparam logic [MISM_W-1:0] MISM_RST = 16'h0000;

    // ==========================================
    // command indices, map code is index plus one, code zero is unused
    localparam int CMD_TORQUE_OFF = 0;
    localparam int CMD_STOP_ONE   = 1;

    // ==========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // startup states
    typedef enum logic [1:0] {
        ST_POWERON,
        ST_DIAG,
        ST_RUN
    } dcsi_state_t;

endpackage

// ==== design/dcsi_top.sv ====
// dual channel safety input conditioning with axi4-lite register access
// assumes raw pins are asynchronous, bus and logic share sys_clk
module dcsi_top #(
    parameter int MS_CYCLES = dcsi_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // safety input pins
    input  wire logic        safe_in_pair1_chan_a,
    input  wire logic        safe_in_pair1_chan_b,
    input  wire logic        safe_in_pair2_chan_a,
    input  wire logic        safe_in_pair2_chan_b,
    input  wire logic        safe_in_pair3_chan_a,
    input  wire logic        safe_in_pair3_chan_b,
    // device side
    input  wire logic        internal_diag_done,
    input  wire logic [11:0] net_cmd,
    output logic [11:0]      axis_a_cmds_q,
    output logic [11:0]      axis_b_cmds_q,
    output logic [11:0]      axis_c_cmds_q,
    output logic             input_mismatch_alarm,
    output logic             stop_one_request,
    output logic             startup_warning,
    output logic             torque_off_release,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    localparam int NP = dcsi_pkg::NUM_PAIRS;
    localparam int NC = dcsi_pkg::NUM_CMDS;

    // ==========================================
    // configuration registers
    logic [31:0]               ctrl_q;
    logic [NC-1:0]             auto_activation_select_q;
    logic [11:0]               map_q;
    logic [dcsi_pkg::FILT_W-1:0] filt_q [NP];
    logic [dcsi_pkg::MISM_W-1:0] mism_q [NP];

    wire [NP-1:0] route_all              = ctrl_q[dcsi_pkg::CTRL_ROUTE_LSB +: NP];
    wire          net_ctrl               = ctrl_q[dcsi_pkg::CTRL_NET_BIT];
    wire [NP-1:0] startup_diag_enable_bits = ctrl_q[dcsi_pkg::CTRL_DIAG_LSB +: NP];

    // ==========================================
    // pin synchronisers
    wire  [2*NP-1:0] pins = {safe_in_pair3_chan_b, safe_in_pair3_chan_a,
                             safe_in_pair2_chan_b, safe_in_pair2_chan_a,
                             safe_in_pair1_chan_b, safe_in_pair1_chan_a};
    logic [2*NP-1:0] sync1_q;
    logic [2*NP-1:0] sync2_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================
    // millisecond tick
    logic [16:0] ms_cnt_q;
    wire         ms_tick = ms_cnt_q == 17'(MS_CYCLES - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 17'h00001;
        end
    end

    // ==========================================
    // per pair filtering and mismatch supervision
    logic [NP-1:0] filt_a;
    logic [NP-1:0] filt_b;
    logic [NP-1:0] pair_on;
    logic [NP-1:0] pair_off;
    logic [NP-1:0] mism_now;
    logic [NP-1:0] mism_trip;
    logic [NP-1:0] mapped;
    logic [dcsi_pkg::MAP_W-1:0] pair_map [NP];
    logic [dcsi_pkg::MISM_W-1:0] mism_cnt_q [NP];

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_pair
            dcsi_filter u_filt_a (
                .sys_clk,
                .rst,
                .raw_in      (sync2_q[2*p]),
                .filt_cycles (filt_q[p]),                               // RULE15
                .level_q     (filt_a[p])
            );
            dcsi_filter u_filt_b (
                .sys_clk,
                .rst,
                .raw_in      (sync2_q[2*p+1]),
                .filt_cycles (filt_q[p]),
                .level_q     (filt_b[p])
            );
            assign pair_on[p]  = filt_a[p] & filt_b[p];                 // RULE1 RULE2
            assign pair_off[p] = ~filt_a[p] & ~filt_b[p];
            assign mism_now[p] = filt_a[p] ^ filt_b[p];
            assign pair_map[p] = map_q[dcsi_pkg::MAP_W*p +: dcsi_pkg::MAP_W]; // RULE14
            assign mapped[p]   = pair_map[p] != '0;
            assign mism_trip[p] = mism_now[p] && (mism_q[p] != '0)      // RULE4 RULE5
                                  && (mism_cnt_q[p] >= mism_q[p]);      // RULE3

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    mism_cnt_q[p] <= '0;
                end else if (!mism_now[p]) begin
                    mism_cnt_q[p] <= '0;
                end else if (ms_tick && mism_cnt_q[p] != '1) begin
                    mism_cnt_q[p] <= mism_cnt_q[p] + 16'h0001;
                end
            end
        end
    endgenerate

    // ==========================================
    // alarm flag, set wins over software clear
    logic alarm_q;
    logic alarm_clr;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alarm_q <= 1'b0;
        end else if ((|mism_trip) && !net_ctrl) begin
            alarm_q <= 1'b1;                                            // RULE3
        end else if (alarm_clr) begin
            alarm_q <= 1'b0;
        end
    end

    // ==========================================
    // startup fixing diagnosis
    dcsi_pkg::dcsi_state_t state_q;
    logic [NP-1:0] seen_off_q;
    logic [NP-1:0] diag_done_q;
    wire  [NP-1:0] diag_sel  = mapped & startup_diag_enable_bits;      // RULE9 RULE10
    wire           all_done  = (diag_done_q & diag_sel) == diag_sel;   // RULE7
    wire           all_on    = (pair_on | ~mapped) == '1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q     <= dcsi_pkg::ST_POWERON;
            seen_off_q  <= '0;
            diag_done_q <= '0;
        end else begin
            case (state_q)
                dcsi_pkg::ST_POWERON: begin
                    if (internal_diag_done) begin
                        state_q <= dcsi_pkg::ST_DIAG;
                    end
                end
                dcsi_pkg::ST_DIAG: begin
                    for (int i = 0; i < NP; i++) begin
                        if (diag_sel[i] && pair_off[i]) begin
                            seen_off_q[i] <= 1'b1;                      // RULE6
                        end
                        if (diag_sel[i] && seen_off_q[i] && pair_on[i]) begin
                            diag_done_q[i] <= 1'b1;
                        end
                    end
                    if (all_done && all_on) begin
                        state_q <= dcsi_pkg::ST_RUN;                    // RULE7 RULE11
                    end
                end
                default: begin
                    state_q <= dcsi_pkg::ST_RUN;
                end
            endcase
        end
    end

    wire released = state_q == dcsi_pkg::ST_RUN;

    // ==========================================
    // command mapping and axis routing
    logic [NC-1:0] pin_cmds;
    logic [NC-1:0] pin_cmds_all;
    logic [NC-1:0] cmds_a;
    logic [NC-1:0] cmds_bc;

    always_comb begin
        pin_cmds     = '0;
        pin_cmds_all = '0;
        for (int i = 0; i < NP; i++) begin
            for (int k = 0; k < NC; k++) begin
                if (pair_map[i] == dcsi_pkg::MAP_W'(k + 1) && pair_on[i]) begin
                    pin_cmds[k] = 1'b1;
                    if (route_all[i]) begin
                        pin_cmds_all[k] = 1'b1;                         // RULE13
                    end
                end
            end
        end
    end

    assign cmds_a  = (net_ctrl ? net_cmd : pin_cmds) | auto_activation_select_q; // RULE12 RULE19
    assign cmds_bc = (net_ctrl ? net_cmd : pin_cmds_all) | auto_activation_select_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            axis_a_cmds_q <= '0;
            axis_b_cmds_q <= '0;
            axis_c_cmds_q <= '0;
        end else begin
            axis_a_cmds_q <= cmds_a;
            axis_b_cmds_q <= cmds_bc;
            axis_c_cmds_q <= cmds_bc;
        end
    end

    assign input_mismatch_alarm = alarm_q;
    assign stop_one_request     = alarm_q;                              // RULE3
    assign startup_warning      = !released;
    assign torque_off_release   = released;

    // ==========================================
    // axi4-lite write path
    logic        aw_have_q;
    logic [7:0]  aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic [31:0] wmask;
    wire         do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    wire hit_ctrl = aw_addr_q == dcsi_pkg::OFF_CTRL;
    wire hit_auto = aw_addr_q == dcsi_pkg::OFF_AUTO;
    wire hit_map  = aw_addr_q == dcsi_pkg::OFF_MAP;
    wire hit_f1   = aw_addr_q == dcsi_pkg::OFF_FILT1;
    wire hit_f2   = aw_addr_q == dcsi_pkg::OFF_FILT2;
    wire hit_f3   = aw_addr_q == dcsi_pkg::OFF_FILT3;
    wire hit_m1   = aw_addr_q == dcsi_pkg::OFF_MISM1;
    wire hit_m2   = aw_addr_q == dcsi_pkg::OFF_MISM2;
    wire hit_m3   = aw_addr_q == dcsi_pkg::OFF_MISM3;
    wire w_ok     = hit_ctrl | hit_auto | hit_map | hit_f1 | hit_f2 | hit_f3
                  | hit_m1 | hit_m2 | hit_m3;
    wire [NP-1:0] hit_f = {hit_f3, hit_f2, hit_f1};
    wire [NP-1:0] hit_m = {hit_m3, hit_m2, hit_m1};

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    wire [31:0] ctrl_new = merge(ctrl_q, w_data_q, wmask);
    assign alarm_clr = do_write && hit_ctrl && w_data_q[dcsi_pkg::CTRL_CLR_BIT]
                       && w_strb_q[1];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dcsi_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_ok ? dcsi_pkg::RESP_OKAY : dcsi_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q                   <= dcsi_pkg::CTRL_RST;
            auto_activation_select_q <= dcsi_pkg::AUTO_RST;
            map_q                    <= dcsi_pkg::MAP_RST;
        end else if (do_write) begin
            if (hit_ctrl) begin
                ctrl_q <= {23'h000000, 1'b0, ctrl_new[7:0]};
            end
            if (hit_auto) begin
                auto_activation_select_q <= NC'(merge(32'(auto_activation_select_q),
                                                      w_data_q, wmask));
            end
            if (hit_map) begin
                map_q <= 12'(merge(32'(map_q), w_data_q, wmask));
            end
        end
    end

    generate
        for (p = 0; p < NP; p++) begin : g_cfg
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    filt_q[p] <= dcsi_pkg::FILT_RST;
                    mism_q[p] <= dcsi_pkg::MISM_RST;
                end else if (do_write) begin
                    if (hit_f[p]) begin
                        filt_q[p] <= dcsi_pkg::FILT_W'(merge(32'(filt_q[p]), w_data_q, wmask));
                    end
                    if (hit_m[p]) begin
                        mism_q[p] <= dcsi_pkg::MISM_W'(merge(32'(mism_q[p]), w_data_q, wmask));
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // axi4-lite read path
    wire [7:0] ra = s_axi_araddr;
    wire [31:0] status_word = {20'h00000, released, startup_warning, alarm_q,
                               mism_now, filt_b, filt_a};
    wire [31:0] rd_val =
        (ra == dcsi_pkg::OFF_CTRL)   ? ctrl_q :
        (ra == dcsi_pkg::OFF_AUTO)   ? 32'(auto_activation_select_q) :
        (ra == dcsi_pkg::OFF_MAP)    ? 32'(map_q) :
        (ra == dcsi_pkg::OFF_FILT1)  ? 32'(filt_q[0]) :
        (ra == dcsi_pkg::OFF_FILT2)  ? 32'(filt_q[1]) :
        (ra == dcsi_pkg::OFF_FILT3)  ? 32'(filt_q[2]) :
        (ra == dcsi_pkg::OFF_MISM1)  ? 32'(mism_q[0]) :
        (ra == dcsi_pkg::OFF_MISM2)  ? 32'(mism_q[1]) :
        (ra == dcsi_pkg::OFF_MISM3)  ? 32'(mism_q[2]) :
        (ra == dcsi_pkg::OFF_STATUS) ? status_word :
        (ra == dcsi_pkg::OFF_CMDS)   ? 32'(axis_a_cmds_q) : 32'h0000_0000;
    wire rd_ok = (ra <= dcsi_pkg::OFF_CMDS) && (ra[1:0] == 2'h0);

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= dcsi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? dcsi_pkg::RESP_OKAY : dcsi_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== tb/dcsi_partner.sv ====
// two-channel switch source driving the raw safety pins
// assumes requested levels change just after a rising edge
module dcsi_partner (
    // clock
    input  wire logic       sys_clk,
    // requested levels per pair
    input  wire logic [2:0] want_a,
    input  wire logic [2:0] want_b,
    // raw pins
    output logic [2:0]      pin_a,
    output logic [2:0]      pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_a = 3'h0;
    initial pin_b = 3'h0;
    always @(posedge sys_clk) pin_a <= want_a;
    always @(negedge sys_clk) pin_b <= want_b;
endmodule

// ==== tb/dcsi_sva.sv ====
// concurrent checks on the ports of the safety input block
// assumes one sys_clk domain with active high rst
module dcsi_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // device side
    input wire logic        internal_diag_done,
    input wire logic [11:0] axis_a_cmds_q,
    input wire logic [11:0] axis_b_cmds_q,
    input wire logic [11:0] axis_c_cmds_q,
    input wire logic        input_mismatch_alarm,
    input wire logic        stop_one_request,
    input wire logic        startup_warning,
    input wire logic        torque_off_release,
    // bus answers
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    property p_rel; torque_off_release == !startup_warning; endproperty
    property p_stop; stop_one_request == input_mismatch_alarm; endproperty
    property p_bc; axis_b_cmds_q == axis_c_cmds_q; endproperty
    property p_sub; (axis_b_cmds_q & ~axis_a_cmds_q) == 12'h000; endproperty
    property p_final; torque_off_release |=> torque_off_release; endproperty
    property p_diag; !internal_diag_done && !torque_off_release |=> !torque_off_release;
    endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rel: assert property (p_rel) else $error("release vs warning");
    a_stop: assert property (p_stop) else $error("stop one vs alarm");
    a_bc: assert property (p_bc) else $error("axes b c differ");
    a_sub: assert property (p_sub) else $error("axis b beyond a");
    a_final: assert property (p_final) else $error("release withdrawn");
    a_diag: assert property (p_diag) else $error("early release");
    a_bhold: assert property (p_bhold) else $error("bresp not held");
    a_rhold: assert property (p_rhold) else $error("rdata not held");
    c_rel: cover property ($rose(torque_off_release));
    c_alarm: cover property ($rose(input_mismatch_alarm));
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind dcsi_top dcsi_sva dcsi_sva_i (.*);

// ==== tb/test_dual_channel_safety_input.sv ====
// self-checking bench for the dual channel safety input block
// assumes dcsi_top, its package and the switch source model
module test_dual_channel_safety_input;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MSC = 20;
    localparam logic [11:0] MAP = 12'h031;
    logic sys_clk = 1'b0, rst = 1'b1, diag_done = 1'b0;
    logic [11:0] net_cmd = 12'h000, cmd_a, cmd_b, cmd_c;
    logic [2:0] want_a = 3'h0, want_b = 3'h0, pin_a, pin_b;
    logic alarm, stop1, warn, rel, s_axi_awready, s_axi_wready, s_axi_arready;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
    logic [19:0] f1;
    int errors = 0, total_checks = 0, cyc = 0;
    dcsi_partner dcsi_partner_i (.*);
    dcsi_top #(.MS_CYCLES(MSC)) dcsi_top_i (.*,
        .safe_in_pair1_chan_a(pin_a[0]), .safe_in_pair1_chan_b(pin_b[0]),
        .safe_in_pair2_chan_a(pin_a[1]), .safe_in_pair2_chan_b(pin_b[1]),
        .safe_in_pair3_chan_a(pin_a[2]), .safe_in_pair3_chan_b(pin_b[2]),
        .internal_diag_done(diag_done), .axis_a_cmds_q(cmd_a),
        .axis_b_cmds_q(cmd_b), .axis_c_cmds_q(cmd_c), .input_mismatch_alarm(alarm),
        .stop_one_request(stop1), .startup_warning(warn), .torque_off_release(rel));
    // ==========================================
    // helpers
    function automatic logic [31:0] cmd_of(input logic [2:0] on, input logic [11:0] au);
        logic [11:0] c;
        c = au;
        for (int p = 0; p < 3; p++)
            if (on[p] && MAP[4*p +: 4] != 4'h0) c[MAP[4*p +: 4] - 4'h1] = 1'b1;
        return {20'h0, c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge sys_clk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge sys_clk);
            s_axi_awvalid <= s_axi_awvalid & ~aw;
            s_axi_wvalid <= s_axi_wvalid & ~w;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar, r;
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(negedge sys_clk);
            {ar, r, rd_q, resp_q} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge sys_clk);
            s_axi_arvalid <= s_axi_arvalid & ~ar;
        end while (!r);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pins(input logic [2:0] a, input logic [2:0] b, input int n);
        @(posedge sys_clk);
        want_a <= a;
        want_b <= b;
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // clock, timeout and sequence
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'hb22cc181));
        f1 = 20'h4 + 20'($urandom_range(7));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(dcsi_pkg::OFF_FILT1);
        chk(rd_q, 32'h0000c350);
        rd(dcsi_pkg::OFF_MISM1);
        chk(rd_q, 32'h0);
        rd(8'h2c);
        chk(32'(resp_q), 32'(dcsi_pkg::RESP_SLVERR));
        wr(dcsi_pkg::OFF_MAP, 32'(MAP));
        wr(dcsi_pkg::OFF_FILT1, 32'(f1));
        wr(dcsi_pkg::OFF_FILT2, 32'(f1 + 20'h1));
        wr(dcsi_pkg::OFF_MISM1, 32'h2);
        wr(dcsi_pkg::OFF_CTRL, 32'h12);
        pins(3'h7, 3'h7, 40);
        diag_done <= 1'b1;
        pins(3'h7, 3'h7, 40);
        chk(32'(rel), 32'h0);
        pins(3'h2, 3'h2, 40);
        chk(32'(rel), 32'h0);
        pins(3'h3, 3'h3, 40);
        chk(32'(rel), 32'h1);
        chk(32'(warn), 32'h0);
        chk(32'(cmd_a), cmd_of(3'h3, 12'h0));
        chk(32'(cmd_b), cmd_of(3'h2, 12'h0));
        pins(3'h3, 3'h1, 100);
        chk(32'(alarm), 32'h0);
        chk(32'(cmd_a), cmd_of(3'h1, 12'h0));
        pins(3'h3, 3'h3, 40);
        pins(3'h3, 3'h2, int'(f1) + 30);
        chk(32'(cmd_a), cmd_of(3'h2, 12'h0));
        chk(32'(alarm), 32'h0);
        repeat (60) @(posedge sys_clk);
        chk(32'(alarm), 32'h1);
        chk(32'(stop1), 32'h1);
        pins(3'h3, 3'h3, 40);
        wr(dcsi_pkg::OFF_AUTO, 32'h020);
        repeat (4) @(posedge sys_clk);
        chk(32'(cmd_a), cmd_of(3'h3, 12'h020));
        chk(32'(cmd_c), cmd_of(3'h2, 12'h020));
        wr(dcsi_pkg::OFF_CTRL, 32'h1a);
        for (int i = 0; i < 6; i++) begin
            net_cmd <= 12'($urandom);
            pins(3'($urandom), 3'($urandom), 30);
            chk(32'(cmd_a), 32'(net_cmd | 12'h020));
            chk(32'(cmd_b), 32'(net_cmd | 12'h020));
        end
        report_and_stop();
    end
endmodule
